// File: design/exec_unit.sv
/*
  Execution unit for skip, set, subtract, swap, table read and xor operations,
  with a local data memory, program memory and an APB register port.
  Assumes a single 25 MHz clock and an APB master that holds each request.
*/
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "exec_unit_params.svh"

module exec_unit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             busy,
  output logic             skip_pending
);

  // --------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------
  logic [7:0]  data_mem [0:255];
  logic [15:0] prog_mem [0:4095];

  logic [7:0]                 acc;
  exec_unit_pkg::flags_s      flags;
  logic [7:0]                 table_pointer_low;
  logic [3:0]                 table_pointer_high;
  logic [7:0]                 table_high_byte_reg;
  exec_unit_pkg::opcode_t     op;
  logic [7:0]                 mem_addr;
  logic [2:0]                 bit_sel;
  logic [7:0]                 literal;
  logic [7:0]                 last_result;
  logic [11:0]                prog_load_addr;
  exec_unit_pkg::exec_state_e state;

  // --------------------------------------------------------------------
  // arithmetic helpers
  // --------------------------------------------------------------------
  function automatic logic [7:0] nib_swap(input logic [7:0] v);
    nib_swap = {v[3:0], v[7:4]};
  endfunction

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  // borrow-style subtract: carry set when no borrow
  function automatic exec_unit_pkg::flags_s sub_flags(input logic [7:0] a,
                                                      input logic [7:0] b);
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] r;
    d = {1'b0, a} - {1'b0, b};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    r = d[7:0];
    sub_flags.carry_flag         = ~d[8];
    sub_flags.half_carry_flag    = ~h[4];
    sub_flags.zero_flag          = is_zero(r);
    sub_flags.overflow_flag      = (a[7] ^ b[7]) & (a[7] ^ r[7]);
    sub_flags.signed_result_flag = r[7] ^ ((a[7] ^ b[7]) & (a[7] ^ r[7]));
    sub_flags.chained_zero_flag  = is_zero(r);
  endfunction

  // --------------------------------------------------------------------
  // operand fetch and result computation
  // --------------------------------------------------------------------
  logic [7:0]            operand;
  logic [7:0]            ptr_low_used;
  logic [11:0]           table_addr;
  logic [15:0]           table_word;
  logic [7:0]            next_acc;
  logic [7:0]            next_mem;
  logic                  mem_we;
  logic                  next_skip;
  exec_unit_pkg::flags_s next_flags;
  logic                  table_op;
  logic                  ptr_inc;

  assign operand = data_mem[mem_addr];

  always_comb begin
    ptr_inc = (op == `OP_TABLE_PAGED_INC) || (op == `OP_TABLE_LAST_INC);
    table_op = ptr_inc || (op == `OP_TABLE_PAGED) || (op == `OP_TABLE_LAST);
    ptr_low_used = ptr_inc ? table_pointer_low + 8'h01 : table_pointer_low;
    if ((op == `OP_TABLE_LAST) || (op == `OP_TABLE_LAST_INC)) begin
      table_addr = {`LAST_PAGE, ptr_low_used};
    end else begin
      table_addr = {table_pointer_high, ptr_low_used};
    end
    table_word = prog_mem[table_addr];
  end

  always_comb begin
    next_acc   = acc;
    next_mem   = operand;
    mem_we     = 1'b0;
    next_skip  = 1'b0;
    next_flags = flags;
    case (op)
      `OP_DEC_TO_ACC_SKIP: begin
        next_acc  = operand - 8'h01;
        next_skip = is_zero(operand - 8'h01);
      end
      `OP_SET_BYTE: begin
        next_mem = 8'hFF;
        mem_we   = 1'b1;
      end
      `OP_SET_BIT: begin
        next_mem = operand | (8'h01 << bit_sel);
        mem_we   = 1'b1;
      end
      `OP_INC_SKIP: begin
        next_mem  = operand + 8'h01;
        mem_we    = 1'b1;
        next_skip = is_zero(operand + 8'h01);
      end
      `OP_INC_TO_ACC_SKIP: begin
        next_acc  = operand + 8'h01;
        next_skip = is_zero(operand + 8'h01);
      end
      `OP_SKIP_NZ_BIT: begin
        next_skip = operand[bit_sel];
      end
      `OP_SKIP_NZ: begin
        next_skip = !is_zero(operand);
      end
      `OP_SUB: begin
        next_acc   = acc - operand;
        next_flags = sub_flags(acc, operand);
      end
      `OP_SUB_TO_MEM: begin
        next_mem   = acc - operand;
        mem_we     = 1'b1;
        next_flags = sub_flags(acc, operand);
      end
      `OP_SUB_IMM: begin
        next_acc   = acc - literal;
        next_flags = sub_flags(acc, literal);
      end
      `OP_SWAP: begin
        next_mem = nib_swap(operand);
        mem_we   = 1'b1;
      end
      `OP_SWAP_TO_ACC: begin
        next_acc = nib_swap(operand);
      end
      `OP_SKIP_Z: begin
        next_skip = is_zero(operand);
      end
      `OP_COPY_SKIP_Z: begin
        next_acc  = operand;
        next_skip = is_zero(operand);
      end
      `OP_SKIP_Z_BIT: begin
        next_skip = !operand[bit_sel];
      end
      `OP_TABLE_PAGED, `OP_TABLE_LAST, `OP_TABLE_PAGED_INC, `OP_TABLE_LAST_INC: begin
        next_mem = table_word[7:0];
        mem_we   = 1'b1;
      end
      `OP_XOR: begin
        next_acc             = acc ^ operand;
        next_flags.zero_flag = is_zero(acc ^ operand);
      end
      `OP_XOR_TO_MEM: begin
        next_mem             = acc ^ operand;
        mem_we               = 1'b1;
        next_flags.zero_flag = is_zero(acc ^ operand);
      end
      `OP_XOR_IMM: begin
        next_acc             = acc ^ literal;
        next_flags.zero_flag = is_zero(acc ^ literal);
      end
      default: begin
        next_acc = acc;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------
  logic apb_wr;
  logic apb_wr_idle;
  logic go;
  logic bad_addr;

  // misaligned or beyond the last register
  function automatic logic addr_unmapped(input logic [11:0] a);
    addr_unmapped = (a[1:0] != 2'b00) || (a > `REG_PROG_LOAD);
  endfunction

  assign apb_wr      = psel && penable && pwrite && pready;
  assign apb_wr_idle = apb_wr && (state == exec_unit_pkg::st_idle);
  assign bad_addr    = addr_unmapped(paddr);

  // --------------------------------------------------------------------
  // register write strobes
  // --------------------------------------------------------------------
  logic wr_cmd;
  logic wr_operand;
  logic wr_acc;
  logic wr_status;
  logic wr_table_ptr;
  logic wr_result;
  logic wr_prog_load;

  // one completed write landing on one offset
  function automatic logic reg_hit(input logic        strobe,
                                   input logic [11:0] a,
                                   input logic [11:0] offset);
    reg_hit = strobe && (a == offset);
  endfunction

  // writes that touch operation state are refused while busy
  assign wr_cmd       = reg_hit(apb_wr_idle, paddr, `REG_CMD);
  assign wr_operand   = reg_hit(apb_wr_idle, paddr, `REG_OPERAND);
  assign wr_acc       = reg_hit(apb_wr_idle, paddr, `REG_ACC);
  assign wr_status    = reg_hit(apb_wr_idle, paddr, `REG_STATUS);
  assign wr_table_ptr = reg_hit(apb_wr_idle, paddr, `REG_TABLE_PTR);
  assign wr_result    = reg_hit(apb_wr_idle, paddr, `REG_RESULT);
  assign wr_prog_load = reg_hit(apb_wr, paddr, `REG_PROG_LOAD);
  assign go           = wr_cmd && pwdata[`CMD_GO_BIT];

  // single wait state: ready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && penable && !pready && bad_addr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready && !pwrite) begin
      case (paddr)
        `REG_CMD:       prdata <= {24'h00_0000, 3'b000, op};
        `REG_OPERAND:   prdata <= {8'h00, literal, 5'b00000, bit_sel, mem_addr};
        `REG_ACC:       prdata <= {24'h00_0000, acc};
        `REG_STATUS:    prdata <= {22'h00_0000, busy, skip_pending, 2'b00, flags};
        `REG_TABLE_PTR: prdata <= {12'h000, table_pointer_high, table_high_byte_reg,
                                   table_pointer_low};
        `REG_RESULT:    prdata <= {24'h00_0000, last_result};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // sequencing: exec cycle, then a dummy cycle when skipping
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= exec_unit_pkg::st_idle;
    end else begin
      case (state)
        exec_unit_pkg::st_idle: begin
          state <= go ? exec_unit_pkg::st_exec : exec_unit_pkg::st_idle;
        end
        exec_unit_pkg::st_exec: begin
          state <= next_skip ? exec_unit_pkg::st_dummy : exec_unit_pkg::st_idle;
        end
        exec_unit_pkg::st_dummy: begin
          state <= exec_unit_pkg::st_idle;
        end
        default: begin
          state <= exec_unit_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy         <= 1'b0;
      skip_pending <= 1'b0;
    end else begin
      busy <= go || (state == exec_unit_pkg::st_exec && next_skip);
      if (state == exec_unit_pkg::st_exec) begin
        skip_pending <= next_skip;
      end else if (go) begin
        skip_pending <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // architectural state
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op       <= 5'h00;
      mem_addr <= 8'h00;
      bit_sel  <= 3'h0;
      literal  <= 8'h00;
    end else begin
      if (wr_cmd) begin
        op <= pwdata[4:0];
      end
      if (wr_operand) begin
        mem_addr <= pwdata[7:0];
        bit_sel  <= pwdata[10:8];
        literal  <= pwdata[23:16];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc   <= 8'h00;
      flags <= '0;
    end else if (state == exec_unit_pkg::st_exec) begin
      acc   <= next_acc;
      flags <= next_flags;
    end else if (wr_acc) begin
      acc <= pwdata[7:0];
    end else if (wr_status) begin
      flags <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_pointer_low   <= 8'h00;
      table_pointer_high  <= 4'h0;
      table_high_byte_reg <= 8'h00;
    end else if (state == exec_unit_pkg::st_exec && table_op) begin
      table_pointer_low   <= ptr_low_used;
      table_high_byte_reg <= table_word[15:8];
    end else if (wr_table_ptr) begin
      table_pointer_low  <= pwdata[7:0];
      table_pointer_high <= pwdata[19:16];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_result    <= 8'h00;
      prog_load_addr <= 12'h000;
    end else begin
      if (state == exec_unit_pkg::st_exec) begin
        last_result <= mem_we ? next_mem : next_acc;
      end
      if (wr_prog_load) begin
        prog_load_addr <= prog_load_addr + 12'h001;
      end else if (wr_table_ptr) begin
        prog_load_addr <= pwdata[31:20];
      end
    end
  end

  // memories carry no reset
  always_ff @(posedge pclk) begin
    if (state == exec_unit_pkg::st_exec && mem_we) begin
      data_mem[mem_addr] <= next_mem;
    end else if (wr_result) begin
      data_mem[mem_addr] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_prog_load) begin
      prog_mem[prog_load_addr] <= pwdata[15:0];
    end
  end

endmodule // exec_unit

`default_nettype wire

// File: design/exec_unit_params.svh
/*
  Constants of the execution unit: operation codes, flag positions, register offsets,
  the last program page and the go bit.
  Assumes a 12-bit program address with 256-word pages, and 16-bit program words.
*/
// Function
// - dec-to-acc skip: acc gets operand minus one, memory kept, skip if zero.
// - every conditional skip that is taken takes two cycles, second one a dummy; one not taken takes one.
// - byte set writes all ones to memory, flags untouched.
// - bit set forces only the chosen bit to one, flags untouched.
// - increment skip writes operand plus one to memory, skips if zero.
// - inc-to-acc skip: acc gets operand plus one, memory kept, skip if zero.
// - non-zero skip on byte or bit skips when value is not zero.
// - subtract memory from acc into acc; carry clear on borrow; all flags updated.
// - subtract-to-memory writes acc minus operand to memory, same flags.
// - immediate subtract takes literal from acc, same borrow carry and flags.
// - nibble swap exchanges halves of the memory byte in place, no flags.
// - swap-to-acc loads acc with swapped byte, memory and flags kept.
// - zero skip skips when whole byte is zero, no flags.
// - copy-and-zero-skip copies byte to acc and skips if zero.
// - bit zero skip skips when the chosen bit is zero.
// - paged table read fetches word at high:low pointer, low to memory.
// - last-page table read uses the low pointer within the final page.
// - incrementing paged read bumps low pointer first, then reads.
// - incrementing last-page read bumps low pointer first, then reads.
// - xor memory into acc, only zero flag updated.
// - xor to memory writes result back, only zero flag updated.
// - immediate xor into acc, only zero flag updated.
`ifndef EXEC_UNIT_PARAMS_SVH
`define EXEC_UNIT_PARAMS_SVH

`define OP_DEC_TO_ACC_SKIP   5'h00
`define OP_SET_BYTE          5'h01
`define OP_SET_BIT           5'h02
`define OP_INC_SKIP          5'h03
`define OP_INC_TO_ACC_SKIP   5'h04
`define OP_SKIP_NZ_BIT       5'h05
`define OP_SKIP_NZ           5'h06
`define OP_SUB               5'h07
`define OP_SUB_TO_MEM        5'h08
`define OP_SUB_IMM           5'h09
`define OP_SWAP              5'h0A
`define OP_SWAP_TO_ACC       5'h0B
`define OP_SKIP_Z            5'h0C
`define OP_COPY_SKIP_Z       5'h0D
`define OP_SKIP_Z_BIT        5'h0E
`define OP_TABLE_PAGED       5'h0F
`define OP_TABLE_LAST        5'h10
`define OP_TABLE_PAGED_INC   5'h11
`define OP_TABLE_LAST_INC    5'h12
`define OP_XOR               5'h13
`define OP_XOR_TO_MEM        5'h14
`define OP_XOR_IMM           5'h15

`define FLAG_C               0
`define FLAG_AC              1
`define FLAG_Z               2
`define FLAG_OV              3
`define FLAG_SC              4
`define FLAG_CZ              5

`define LAST_PAGE            4'hF

`define REG_CMD              12'h000
`define REG_OPERAND          12'h004
`define REG_ACC              12'h008
`define REG_STATUS           12'h00C
`define REG_TABLE_PTR        12'h010
`define REG_RESULT           12'h014
`define REG_PROG_LOAD        12'h018

`define CMD_GO_BIT           31

`endif

// File: design/exec_unit_pkg.sv
/*
  Types of the execution unit: the operation code, the flag set and the
  program memory access.
  Assumes the constants header is compiled first.
*/
`include "exec_unit_params.svh"
package exec_unit_pkg;
  typedef logic [4:0] opcode_t;

  typedef struct packed {
    logic chained_zero_flag;
    logic signed_result_flag;
    logic overflow_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
  } flags_s;

  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] data;
  } prog_word_s;

  typedef enum logic [1:0] {st_idle, st_exec, st_dummy} exec_state_e;
endpackage

// File: tb/apb_host.sv
/*
  apb master model that drives the register port of the execution unit.
  assumes a free running pclk and a slave that raises pready when it answers.
*/
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// apb master
// ----------------------------------------
module apb_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end

  // setup, access held until pready, then release with inverted data
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
    @(posedge pclk);
  endtask
endmodule // apb_host
`default_nettype wire

// File: tb/exec_unit_checker.sv
/*
  concurrent checks on the ports of the execution unit.
  assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
`include "exec_unit_params.svh"
// ----------------------------------------
// port checker
// ----------------------------------------
module exec_unit_checker (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        busy,
  input  wire logic        skip_pending
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic go_acc;
  logic bad_addr;
  assign go_acc   = psel && penable && pready && pwrite && paddr == `REG_CMD
                    && pwdata[`CMD_GO_BIT];
  assign bad_addr = paddr > `REG_PROG_LOAD || paddr[1:0] != 2'h0;

  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_ready_timing: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready not in second access cycle");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  chk_err_unmapped: assert property (psel && penable && !pready && bad_addr |=> pslverr)
    else $error("no error on unmapped access");
  chk_err_mapped: assert property (pready && !bad_addr |-> !pslverr)
    else $error("error on mapped access");
  chk_busy_start: assert property (go_acc && !busy |=> ##[0:1] busy)
    else $error("go accepted but unit not busy");
  chk_busy_bound: assert property ($rose(busy) |-> ##[1:3] !busy)
    else $error("operation runs too long");
  chk_skip_dummy: assert property ($fell(busy) && skip_pending |-> $past(busy, 2))
    else $error("skip without dummy cycle");
endmodule // exec_unit_checker
`default_nettype wire

// File: tb/testbench.sv
/*
  self-checking bench for the execution unit, run through its register port.
  assumes the apb host model and the checker are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "exec_unit_params.svh"
// ----------------------------------------
// testbench
// ----------------------------------------
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic        skip_pending;
  logic [31:0] q;
  logic        err;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cycles = 0;

  exec_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .skip_pending(skip_pending));
  apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic summarize;
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    host.xfer(1'b1, a, d, x, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    host.xfer(1'b0, a, 32'h0, d, e);
  endtask

  // start an operation and poll busy, returning the status word
  task automatic go(input exec_unit_pkg::opcode_t op, output logic [31:0] s);
    wr(`REG_CMD, {1'b1, 26'h0, op});
    s = 32'h200;
    for (int i = 0; i < 20 && s[9] !== 1'b0; i++) rd(`REG_STATUS, s);
    chk(s[9], 1'b0);
  endtask

  // memory byte at 0x40 = m, acc = a, flags preset 0x2A; check acc, skip, flags, memory
  task automatic op_chk(input exec_unit_pkg::opcode_t op, input logic [7:0] lit,
    input logic [2:0] bn, input logic [7:0] m, input logic [7:0] a, input logic [7:0] ea,
    input logic [7:0] em, input logic es, input logic [5:0] ef);
    logic [31:0] s;
    logic [31:0] v;
    wr(`REG_OPERAND, {8'h00, lit, 5'h00, bn, 8'h40});
    wr(`REG_RESULT, {24'h0, m});
    wr(`REG_ACC, {24'h0, a});
    wr(`REG_STATUS, 32'h2A);
    go(op, s);
    rd(`REG_ACC, v);
    chk(v[7:0], ea);
    chk({s[8], s[5:0]}, {es, ef});
    chk({busy, skip_pending}, {1'b0, es});
    go(`OP_COPY_SKIP_Z, s);
    rd(`REG_ACC, v);
    chk(v[7:0], em);
    rd(`REG_RESULT, v);
    chk(v[7:0], em);
  endtask

  task automatic tab(input exec_unit_pkg::opcode_t op, input logic [3:0] hi,
    input logic [7:0] lo, input logic [7:0] elo, input logic [7:0] ehi, input logic [7:0] ep);
    logic [31:0] v;
    wr(`REG_TABLE_PTR, {12'h000, hi, 8'h00, lo});
    op_chk(op, 8'h00, 3'h0, 8'h00, 8'h77, 8'h77, elo, 1'b0, 6'h2A);
    rd(`REG_TABLE_PTR, v);
    chk(v[15:0], {ehi, ep});
  endtask

  initial begin
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    op_chk(`OP_DEC_TO_ACC_SKIP, 8'h00, 3'h0, 8'h01, 8'h77, 8'h00, 8'h01, 1'b1, 6'h2A);
    op_chk(`OP_DEC_TO_ACC_SKIP, 8'h00, 3'h0, 8'h05, 8'h77, 8'h04, 8'h05, 1'b0, 6'h2A);
    op_chk(`OP_SET_BYTE, 8'h00, 3'h0, 8'h12, 8'h77, 8'h77, 8'hFF, 1'b0, 6'h2A);
    op_chk(`OP_SET_BIT, 8'h00, 3'h5, 8'h81, 8'h77, 8'h77, 8'hA1, 1'b0, 6'h2A);
    op_chk(`OP_SET_BIT, 8'h00, 3'h7, 8'h00, 8'h77, 8'h77, 8'h80, 1'b0, 6'h2A);
    op_chk(`OP_INC_SKIP, 8'h00, 3'h0, 8'hFF, 8'h77, 8'h77, 8'h00, 1'b1, 6'h2A);
    op_chk(`OP_INC_SKIP, 8'h00, 3'h0, 8'h7F, 8'h77, 8'h77, 8'h80, 1'b0, 6'h2A);
    op_chk(`OP_INC_TO_ACC_SKIP, 8'h00, 3'h0, 8'hFF, 8'h77, 8'h00, 8'hFF, 1'b1, 6'h2A);
    op_chk(`OP_INC_TO_ACC_SKIP, 8'h00, 3'h0, 8'h10, 8'h77, 8'h11, 8'h10, 1'b0, 6'h2A);
    op_chk(`OP_SKIP_NZ_BIT, 8'h00, 3'h3, 8'h08, 8'h77, 8'h77, 8'h08, 1'b1, 6'h2A);
    op_chk(`OP_SKIP_NZ_BIT, 8'h00, 3'h2, 8'h08, 8'h77, 8'h77, 8'h08, 1'b0, 6'h2A);
    op_chk(`OP_SKIP_NZ, 8'h00, 3'h0, 8'h01, 8'h77, 8'h77, 8'h01, 1'b1, 6'h2A);
    op_chk(`OP_SKIP_NZ, 8'h00, 3'h0, 8'h00, 8'h77, 8'h77, 8'h00, 1'b0, 6'h2A);
    op_chk(`OP_SUB, 8'h00, 3'h0, 8'h07, 8'h05, 8'hFE, 8'h07, 1'b0, 6'h10);
    op_chk(`OP_SUB, 8'h00, 3'h0, 8'h07, 8'h07, 8'h00, 8'h07, 1'b0, 6'h27);
    op_chk(`OP_SUB_TO_MEM, 8'h00, 3'h0, 8'h01, 8'h10, 8'h10, 8'h0F, 1'b0, 6'h01);
    op_chk(`OP_SUB_IMM, 8'h01, 3'h0, 8'h55, 8'h80, 8'h7F, 8'h55, 1'b0, 6'h19);
    op_chk(`OP_SWAP, 8'h00, 3'h0, 8'h3C, 8'h77, 8'h77, 8'hC3, 1'b0, 6'h2A);
    op_chk(`OP_SWAP_TO_ACC, 8'h00, 3'h0, 8'h3C, 8'h77, 8'hC3, 8'h3C, 1'b0, 6'h2A);
    op_chk(`OP_SKIP_Z, 8'h00, 3'h0, 8'h00, 8'h77, 8'h77, 8'h00, 1'b1, 6'h2A);
    op_chk(`OP_SKIP_Z, 8'h00, 3'h0, 8'h10, 8'h77, 8'h77, 8'h10, 1'b0, 6'h2A);
    op_chk(`OP_COPY_SKIP_Z, 8'h00, 3'h0, 8'h00, 8'h77, 8'h00, 8'h00, 1'b1, 6'h2A);
    op_chk(`OP_COPY_SKIP_Z, 8'h00, 3'h0, 8'h9A, 8'h77, 8'h9A, 8'h9A, 1'b0, 6'h2A);
    op_chk(`OP_SKIP_Z_BIT, 8'h00, 3'h6, 8'hBF, 8'h77, 8'h77, 8'hBF, 1'b1, 6'h2A);
    op_chk(`OP_SKIP_Z_BIT, 8'h00, 3'h6, 8'h40, 8'h77, 8'h77, 8'h40, 1'b0, 6'h2A);
    op_chk(`OP_XOR, 8'h00, 3'h0, 8'h5A, 8'h5A, 8'h00, 8'h5A, 1'b0, 6'h2E);
    op_chk(`OP_XOR, 8'h00, 3'h0, 8'h0F, 8'hF0, 8'hFF, 8'h0F, 1'b0, 6'h2A);
    op_chk(`OP_XOR_TO_MEM, 8'h00, 3'h0, 8'h0F, 8'h3C, 8'h3C, 8'h33, 1'b0, 6'h2A);
    op_chk(`OP_XOR_TO_MEM, 8'h00, 3'h0, 8'h3C, 8'h3C, 8'h3C, 8'h00, 1'b0, 6'h2E);
    op_chk(`OP_XOR_IMM, 8'hA5, 3'h0, 8'h11, 8'hA5, 8'h00, 8'h11, 1'b0, 6'h2E);
    op_chk(`OP_XOR_IMM, 8'h01, 3'h0, 8'h11, 8'h80, 8'h81, 8'h11, 1'b0, 6'h2A);
    wr(`REG_TABLE_PTR, 32'h2340_0000);
    wr(`REG_PROG_LOAD, 32'h0000_BEEF);
    wr(`REG_TABLE_PTR, 32'hF350_0000);
    wr(`REG_PROG_LOAD, 32'h0000_1234);
    tab(`OP_TABLE_PAGED, 4'h2, 8'h34, 8'hEF, 8'hBE, 8'h34);
    tab(`OP_TABLE_LAST, 4'h2, 8'h35, 8'h34, 8'h12, 8'h35);
    tab(`OP_TABLE_PAGED_INC, 4'h2, 8'h33, 8'hEF, 8'hBE, 8'h34);
    tab(`OP_TABLE_LAST_INC, 4'h0, 8'h34, 8'h34, 8'h12, 8'h35);
    host.xfer(1'b0, 12'h01C, 32'h0, q, err);
    chk(q, 32'h0);
    chk(err, 1'b1);
    summarize();
  end

  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles > 30000) begin
      fail_count++;
      summarize();
    end
  end
endmodule // testbench

bind exec_unit exec_unit_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .busy(busy), .skip_pending(skip_pending));
`default_nettype wire
